/* src/plrc_top.sv */
// Purpose: port indicator rule controller, rule words to open-drain lamp pins
// Assumes: port status from core logic on CORE_CLK, lamp pins pulled up outside
// Notes:   a lit lamp is the pin driven low; the pin level reads back at 0x0BC
`timescale 1ns/10ps
module plrc_top #(
	parameter int TICK_CYCLES = plrc_pkg::TICK_CYC
) (
	input  wire logic                                            CORE_CLK,
	input  wire logic                                            RST_N,
	input  wire plrc_pkg::plrc_reg_req_type                      REG_REQ,
	output      logic [31:0]                                     REG_RDATA,
	output      logic                                            REG_ACK,
	input  wire plrc_pkg::plrc_port_stat_type [plrc_pkg::N_PORT-1:0] PORT_STAT,
	input  wire logic [plrc_pkg::N_PHY_LED-1:0]                  PHY_LED_I,
	output      logic [plrc_pkg::N_PHY_LED-1:0]                  PHY_LED_O,
	output      logic [plrc_pkg::N_PHY_LED-1:0]                  PHY_LED_OE,
	input  wire logic [plrc_pkg::N_MAC-1:0]                      MAC_LED_I,
	output      logic [plrc_pkg::N_MAC-1:0]                      MAC_LED_O,
	output      logic [plrc_pkg::N_MAC-1:0]                      MAC_LED_OE
);
	import plrc_pkg::*;

	logic [RULE_W-1:0]     rule_r [N_RULE];
	logic [TICK_CNT_W-1:0] tick_cnt_r;
	logic                  tick;
	logic [PH_W-1:0]       ph_r;
	logic [POR_CNT_W-1:0]  por_cnt_r;
	plrc_state_type        state_r;
	logic                  por_show;
	logic [N_PHY_LED-1:0]  phy_on;
	logic [N_MAC-1:0]      mac_on;
	logic [N_PIN-1:0]      pin_s1_r;
	logic [N_PIN-1:0]      pin_s2_r;
	logic                  wr_a;
	logic                  wr_b;
	logic                  wr_mac;
	logic [31:0]           rdata_nxt;

	////////////////////////////////////////////////////////////////////////////
	// lamp decision for one rule word and one port
	function automatic logic led_eval(input logic [RULE_W-1:0] rule,
		input plrc_port_stat_type st, input logic [PH_W-1:0] ph, input logic por);
		logic speed_glow;
		logic steady;
		logic act;
		logic flash;
		logic rate_ph;
		speed_glow = st.link_up & ((rule[F_GIGABIT_GLOW_ENABLE] & (st.speed == SPD_1000))
			| (rule[F_FAST_SPEED_GLOW_ENABLE] & (st.speed == SPD_100))
			| (rule[F_SLOW_SPEED_GLOW_ENABLE] & (st.speed == SPD_10)));
		steady = speed_glow
			| (rule[F_FULL_DUPLEX_GLOW_ENABLE] & st.link_up & st.full_dup)
			| (rule[F_HALF_DUPLEX_GLOW_ENABLE] & st.link_up & ~st.full_dup);
		act = (rule[F_RX_FLASH_ENABLE] & st.rx_act)
			| (rule[F_TX_FLASH_ENABLE] & st.tx_act);
		if (rule[F_LINK_GATED_FLASH_ENABLE]) begin
			act = act & speed_glow;
		end
		flash = act | (rule[F_COLLISION_FLASH_ENABLE] & st.col);
		unique case (plrc_rate_type'(rule[F_FLASH_RATE_SELECT_HI:F_FLASH_RATE_SELECT_LO]))
			RATE_2HZ: rate_ph = ph[PH_2HZ];
			RATE_4HZ: rate_ph = ph[PH_4HZ];
			RATE_8HZ: rate_ph = ph[PH_8HZ];
			RATE_SPEED: begin
				rate_ph = (st.link_up && st.speed == SPD_10) ? ph[PH_2HZ] : ph[PH_4HZ];
			end
		endcase
		if (por && rule[F_POWER_ON_GLOW_ENABLE]) begin
			led_eval = 1'b1;
		end else begin
			unique case (plrc_pattern_type'(rule[F_PATTERN_HI:F_PATTERN_LO]))
				PAT_OFF:    led_eval = 1'b0;
				PAT_FLASH4: led_eval = ph[PH_4HZ];
				PAT_ON:     led_eval = 1'b1;
				PAT_RULE:   led_eval = flash ? rate_ph : steady;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// blink time base: phase ticks at twice 8 Hz, phase bits are square waves
	assign tick = (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1));

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt_r <= '0;
			ph_r       <= '0;
		end else begin
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
			ph_r       <= tick ? ph_r + 1'b1 : ph_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power-on indication window after reset release
	assign por_show = (state_r == ST_POR_SHOW);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r   <= ST_POR_SHOW;
			por_cnt_r <= '0;
		end else if (por_show && tick) begin
			por_cnt_r <= por_cnt_r + 1'b1;
			if (por_cnt_r == POR_CNT_W'(POR_TICKS - 1)) begin
				state_r <= ST_RUN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register port decode, high half of a pair word is the second rule
	assign wr_a   = REG_REQ.wr & (REG_REQ.addr == OFS_RULE_PAIR_A);
	assign wr_b   = REG_REQ.wr & (REG_REQ.addr == OFS_RULE_PAIR_B);
	assign wr_mac = REG_REQ.wr & (REG_REQ.addr == OFS_MAC_RULE);
	assign rdata_nxt =
		(REG_REQ.addr == OFS_RULE_PAIR_A) ? {rule_r[RI_PAIR_A+1], rule_r[RI_PAIR_A]} :
		(REG_REQ.addr == OFS_RULE_PAIR_B) ? {rule_r[RI_PAIR_B+1], rule_r[RI_PAIR_B]} :
		(REG_REQ.addr == OFS_MAC_RULE)    ? {16'h0000, rule_r[RI_MAC]} :
		(REG_REQ.addr == OFS_PIN_STATE)   ? {{(32-N_PIN){1'b0}}, pin_s2_r} : 32'h0000_0000;

	// rule words, five of them
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rule_r[RI_PAIR_A]   <= RST_PHY_INDICATOR_RULE_PAIR_A;
			rule_r[RI_PAIR_A+1] <= RST_PHY_INDICATOR_RULE_PAIR_A;
			rule_r[RI_PAIR_B]   <= RST_PHY_INDICATOR_RULE_PAIR_B;
			rule_r[RI_PAIR_B+1] <= RST_PHY_INDICATOR_RULE_PAIR_B;
			rule_r[RI_MAC]      <= RST_MAC_PORT_INDICATOR_RULE;
		end else begin
			if (wr_a) begin
				rule_r[RI_PAIR_A]   <= REG_REQ.wdata[15:0];
				rule_r[RI_PAIR_A+1] <= REG_REQ.wdata[31:16];
			end
			if (wr_b) begin
				rule_r[RI_PAIR_B]   <= REG_REQ.wdata[15:0];
				rule_r[RI_PAIR_B+1] <= REG_REQ.wdata[31:16];
			end
			if (wr_mac) begin
				rule_r[RI_MAC] <= REG_REQ.wdata[15:0];
			end
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= '0;
			REG_ACK   <= 1'b0;
		end else begin
			REG_RDATA <= REG_REQ.rd ? rdata_nxt : REG_RDATA;
			REG_ACK   <= REG_REQ.wr | REG_REQ.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-lamp evaluation, two lamps per phy port and one per mac port
	for (genvar p = 0; p < N_PHY; p++) begin : g_phy
		for (genvar l = 0; l < 2; l++) begin : g_led
			localparam int RI = ((p == PAIR_B_PORT) ? RI_PAIR_B : RI_PAIR_A) + l;
			assign phy_on[2*p+l] = led_eval(rule_r[RI], PORT_STAT[p], ph_r, por_show);
		end
	end
	for (genvar m = 0; m < N_MAC; m++) begin : g_mac
		assign mac_on[m] = led_eval(rule_r[RI_MAC], PORT_STAT[N_PHY+m], ph_r, por_show);
	end

	// open-drain drive, pin levels synchronised for readback
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PHY_LED_OE <= '0;
			MAC_LED_OE <= '0;
			PHY_LED_O  <= '0;
			MAC_LED_O  <= '0;
			pin_s1_r   <= '0;
			pin_s2_r   <= '0;
		end else begin
			PHY_LED_OE <= phy_on;
			MAC_LED_OE <= mac_on;
			PHY_LED_O  <= '0;
			MAC_LED_O  <= '0;
			pin_s1_r   <= {MAC_LED_I, PHY_LED_I};
			pin_s2_r   <= pin_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks, lamp 0 of phy port 0 and mac lamp 0
	logic first_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_rule_mode;
		!por_show && !wr_a && (rule_r[RI_PAIR_A][F_PATTERN_HI:F_PATTERN_LO] == PAT_RULE);
	endsequence

	reset_words_a: assert property (first_r |-> rule_r[RI_MAC] == RST_MAC_PORT_INDICATOR_RULE
		&& rule_r[RI_PAIR_A] == RST_PHY_INDICATOR_RULE_PAIR_A
		&& rule_r[RI_PAIR_B+1] == RST_PHY_INDICATOR_RULE_PAIR_B)
		else $error("rule word reset value wrong");
	mac_write_a: assert property (wr_mac |=> rule_r[RI_MAC] == $past(REG_REQ.wdata[15:0])
		##1 ($past(rule_r[RI_MAC][F_PATTERN_HI:F_PATTERN_LO]) != PAT_ON || MAC_LED_OE[0]))
		else $error("mac rule write not applied");
	pattern_off_a: assert property (!por_show && !wr_a
		&& rule_r[RI_PAIR_A][F_PATTERN_HI:F_PATTERN_LO] == PAT_OFF |=> !PHY_LED_OE[0])
		else $error("forced-off lamp lit");
	pattern_on_a: assert property (rule_r[RI_PAIR_A][F_PATTERN_HI:F_PATTERN_LO] == PAT_ON
		|=> PHY_LED_OE[0])
		else $error("forced-on lamp dark");
	por_show_a: assert property (por_show && rule_r[RI_MAC][F_POWER_ON_GLOW_ENABLE]
		|=> MAC_LED_OE[0])
		else $error("power-on indication missing");
	full_glow_a: assert property (s_rule_mode ##0 (rule_r[RI_PAIR_A][F_FULL_DUPLEX_GLOW_ENABLE]
		&& PORT_STAT[0].link_up && PORT_STAT[0].full_dup && !PORT_STAT[0].col
		&& !PORT_STAT[0].rx_act && !PORT_STAT[0].tx_act) |=> PHY_LED_OE[0])
		else $error("full-duplex lamp dark");
	speed_glow_a: assert property (s_rule_mode ##0 (rule_r[RI_PAIR_A][F_SLOW_SPEED_GLOW_ENABLE]
		&& PORT_STAT[0].link_up && PORT_STAT[0].speed == SPD_10 && !PORT_STAT[0].col
		&& !PORT_STAT[0].rx_act && !PORT_STAT[0].tx_act) |=> PHY_LED_OE[0])
		else $error("speed lamp dark");
	gated_off_a: assert property (s_rule_mode ##0 (rule_r[RI_PAIR_A][15:0] == 16'hC116
		&& PORT_STAT[0].tx_act && PORT_STAT[0].speed != SPD_10) |=> !PHY_LED_OE[0])
		else $error("gated flash without speed light");
	col_rate_a: assert property (s_rule_mode ##0 (rule_r[RI_PAIR_A][15:0] == 16'hC082
		&& PORT_STAT[0].col) |=> PHY_LED_OE[0] == $past(ph_r[PH_8HZ]))
		else $error("collision flash at wrong rate");
	speed_rate_a: assert property (s_rule_mode ##0 (rule_r[RI_PAIR_A][15:0] == 16'hC013
		&& PORT_STAT[0].tx_act && PORT_STAT[0].link_up && PORT_STAT[0].speed == SPD_10)
		|=> PHY_LED_OE[0] == $past(ph_r[PH_2HZ]))
		else $error("speed-following rate wrong");

endmodule // plrc_top

/* src/plrc_pkg.sv */
// Purpose: shared constants and types of the port indicator rule controller
// Assumes: 50 MHz core clock, register port at byte offsets 0x0B0..0x0BC
// Notes:   rule word layout, reset values and blink timing live here only
package plrc_pkg;

	// timing
	localparam int CLK_MHZ       = 50;
	localparam int TICK_HALF_US  = 62500;                     // half period of 8 Hz flashing
	localparam int TICK_CYC      = TICK_HALF_US * CLK_MHZ;    // core cycles per phase tick
	localparam int TICK_CNT_W    = 22;
	localparam int POR_SHOW_MS   = 500;                       // power-on indication length
	localparam int POR_TICKS     = (POR_SHOW_MS * 1000) / TICK_HALF_US;
	localparam int POR_CNT_W     = 4;

	// geometry
	localparam int N_RULE        = 5;
	localparam int N_PHY         = 5;
	localparam int N_MAC         = 3;
	localparam int N_PORT        = N_PHY + N_MAC;
	localparam int N_PHY_LED     = 2 * N_PHY;
	localparam int N_PIN         = N_PHY_LED + N_MAC;
	localparam int RULE_W        = 16;
	localparam int PH_W          = 3;

	// rule word indices and led mapping
	localparam int RI_PAIR_A     = 0;                         // indices 0,1: phy ports 0..3
	localparam int RI_PAIR_B     = 2;                         // indices 2,3: phy port 4
	localparam int RI_MAC        = 4;
	localparam int PAIR_B_PORT   = 4;

	// register offsets
	localparam logic [7:0] OFS_RULE_PAIR_A = 8'hB0;
	localparam logic [7:0] OFS_RULE_PAIR_B = 8'hB4;
	localparam logic [7:0] OFS_MAC_RULE    = 8'hB8;
	localparam logic [7:0] OFS_PIN_STATE   = 8'hBC;

	// reset values
	localparam logic [15:0] RST_MAC_PORT_INDICATOR_RULE   = 16'hCF35;
	localparam logic [15:0] RST_PHY_INDICATOR_RULE_PAIR_A = 16'hC935;
	localparam logic [15:0] RST_PHY_INDICATOR_RULE_PAIR_B = 16'hCA35;

	// rule word fields
	localparam int F_PATTERN_HI                = 15;
	localparam int F_PATTERN_LO                = 14;
	localparam int F_FULL_DUPLEX_GLOW_ENABLE   = 13;
	localparam int F_HALF_DUPLEX_GLOW_ENABLE   = 12;
	localparam int F_POWER_ON_GLOW_ENABLE      = 11;
	localparam int F_GIGABIT_GLOW_ENABLE       = 10;
	localparam int F_FAST_SPEED_GLOW_ENABLE    = 9;
	localparam int F_SLOW_SPEED_GLOW_ENABLE    = 8;
	localparam int F_COLLISION_FLASH_ENABLE    = 7;
	localparam int F_RX_FLASH_ENABLE           = 5;
	localparam int F_TX_FLASH_ENABLE           = 4;
	localparam int F_LINK_GATED_FLASH_ENABLE   = 2;
	localparam int F_FLASH_RATE_SELECT_HI      = 1;
	localparam int F_FLASH_RATE_SELECT_LO      = 0;

	// phase counter bits giving each square wave
	localparam int PH_8HZ        = 0;
	localparam int PH_4HZ        = 1;
	localparam int PH_2HZ        = 2;

	typedef enum logic [1:0] {
		PAT_OFF    = 2'h0,
		PAT_FLASH4 = 2'h1,
		PAT_ON     = 2'h2,
		PAT_RULE   = 2'h3
	} plrc_pattern_type;

	typedef enum logic [1:0] {
		RATE_2HZ   = 2'h0,
		RATE_4HZ   = 2'h1,
		RATE_8HZ   = 2'h2,
		RATE_SPEED = 2'h3
	} plrc_rate_type;

	typedef enum logic [1:0] {
		SPD_10     = 2'h0,
		SPD_100    = 2'h1,
		SPD_1000   = 2'h2
	} plrc_speed_type;

	typedef enum logic {
		ST_POR_SHOW = 1'b0,
		ST_RUN      = 1'b1
	} plrc_state_type;

	typedef struct packed {
		logic           link_up;
		logic           full_dup;
		plrc_speed_type speed;
		logic           col;
		logic           rx_act;
		logic           tx_act;
	} plrc_port_stat_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} plrc_reg_req_type;

endpackage

/* tb/plrc_lamp_model.sv */
// Purpose: external lamps on the open-drain indicator pins
// Assumes: each pin has a pull-up outside the chip
// Notes:   a released pin reads high, a driven pin reads the driven level
`timescale 1ns/10ps
module plrc_lamp_model (
	input  wire logic [9:0] phy_o,
	input  wire logic [9:0] phy_oe,
	input  wire logic [2:0] mac_o,
	input  wire logic [2:0] mac_oe,
	output      logic [9:0] phy_pin,
	output      logic [2:0] mac_pin
);
	////////////////////////////////////////////////////////////////
	// pull-up wins wherever the chip lets go
	assign phy_pin = (phy_oe & phy_o) | ~phy_oe;
	assign mac_pin = (mac_oe & mac_o) | ~mac_oe;
endmodule // plrc_lamp_model

/* tb/port_led_rule_controller_tb.sv */
// Purpose: self-checking bench of the indicator rule controller
// Assumes: short phase tick so each flash rate fits a short run
// Notes:   inputs change on the falling edge only
`timescale 1ns/10ps
module port_led_rule_controller_tb;
	import plrc_pkg::*;
	localparam int TICKS = 4;
	logic                                core_clk = 1'b0;
	logic                                rst_n = 1'b0;
	plrc_reg_req_type                    reg_req = '0;
	plrc_port_stat_type [N_PORT-1:0]     port_stat = '0;
	logic [31:0]                         rdata;
	logic                                ack;
	logic [9:0]                          phy_o, phy_oe, phy_pin;
	logic [2:0]                          mac_o, mac_oe, mac_pin;
	logic [12:0]                         lamps;
	int                                  err_count = 0;
	int                                  n_checks = 0;
	logic [31:0]                         q;

	assign lamps = {mac_oe, phy_oe};
	always #10 core_clk = ~core_clk;

	plrc_top #(.TICK_CYCLES(TICKS)) dut (
		.CORE_CLK(core_clk), .RST_N(rst_n), .REG_REQ(reg_req), .REG_RDATA(rdata),
		.REG_ACK(ack), .PORT_STAT(port_stat), .PHY_LED_I(phy_pin), .PHY_LED_O(phy_o),
		.PHY_LED_OE(phy_oe), .MAC_LED_I(mac_pin), .MAC_LED_O(mac_o), .MAC_LED_OE(mac_oe));
	plrc_lamp_model lamps_ext (.phy_o(phy_o), .phy_oe(phy_oe), .mac_o(mac_o),
		.mac_oe(mac_oe), .phy_pin(phy_pin), .mac_pin(mac_pin));

	////////////////////////////////////////////////////////////////
	// verdict and comparison
	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// register port: one-cycle strobe, bounded wait for ack
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(negedge core_clk);
		reg_req.wr = w;
		reg_req.rd = ~w;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(negedge core_clk);
		reg_req = '0;
		for (i = 0; i < 4 && ack !== 1'b1; i++) @(negedge core_clk);
		if (ack !== 1'b1) begin
			err_count++;
			wrap_up();
		end else begin
			q = rdata;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		xfer(1'b0, a, 32'h0);
		chk(what, q, exp);
	endtask
	task automatic set0(input logic [15:0] rule);
		xfer(1'b1, OFS_RULE_PAIR_A, {16'h0000, rule & ~16'h0048});
	endtask

	////////////////////////////////////////////////////////////////
	// lamp observation: count lit samples and changes
	task automatic measure(input int idx, input int n, output int highs, output int trans);
		logic prev;
		repeat (3) @(negedge core_clk);
		highs = 0;
		trans = 0;
		prev = lamps[idx];
		repeat (n) begin
			@(negedge core_clk);
			highs += int'(lamps[idx]);
			trans += int'(lamps[idx] != prev);
			prev = lamps[idx];
		end
	endtask
	task automatic lvl(input logic v);
		int h, t;
		measure(0, 16, h, t);
		chk("lamp level", h, v ? 32'd16 : 32'd0);
	endtask
	task automatic rate(input int half);
		int h, t;
		measure(0, 64, h, t);
		chk("flash duty", h, 32'd32);
		chk("flash rate", 32'(t == 64 / half || t == 64 / half - 1), 32'd1);
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("power-on lamps", 32'(lamps), 32'h1FFF);
		rd_chk(OFS_RULE_PAIR_A, {2{RST_PHY_INDICATOR_RULE_PAIR_A}}, "pair a");
		rd_chk(OFS_RULE_PAIR_B, {2{RST_PHY_INDICATOR_RULE_PAIR_B}}, "pair b");
		rd_chk(OFS_MAC_RULE, {16'h0000, RST_MAC_PORT_INDICATOR_RULE}, "mac rule");
		repeat (40) @(negedge core_clk);
		chk("idle lamps", 32'(lamps), 32'h0);
		set0(16'h0000);
		lvl(1'b0);
		set0(16'h8000);
		lvl(1'b1);
		set0(16'h4000);
		rate(8);
		port_stat[0].link_up = 1'b1;
		port_stat[0].full_dup = 1'b1;
		port_stat[0].speed = SPD_100;
		set0(16'hE000);
		lvl(1'b1);
		port_stat[0].full_dup = 1'b0;
		lvl(1'b0);
		set0(16'hD000);
		lvl(1'b1);
		port_stat[0].link_up = 1'b0;
		lvl(1'b0);
		port_stat[0].link_up = 1'b1;
		for (int s = 0; s < 3; s++) begin
			for (int b = 0; b < 3; b++) begin
				port_stat[0].speed = plrc_speed_type'(s);
				set0(16'hC000 | (16'h0100 << b));
				lvl(s == b);
			end
		end
		port_stat[0].link_up = 1'b0;
		port_stat[0].col = 1'b1;
		for (int r = 0; r < 3; r++) begin
			set0(16'hC080 | 16'(r));
			rate(16 >> r);
		end
		port_stat[0].col = 1'b0;
		port_stat[0].rx_act = 1'b1;
		set0(16'hC022);
		rate(4);
		port_stat[0].rx_act = 1'b0;
		port_stat[0].tx_act = 1'b1;
		set0(16'hC012);
		rate(4);
		port_stat[0].link_up = 1'b1;
		port_stat[0].speed = SPD_100;
		set0(16'hC013);
		rate(8);
		port_stat[0].speed = SPD_10;
		rate(16);
		port_stat[0].speed = SPD_100;
		set0(16'hC116);
		lvl(1'b0);
		port_stat[0].speed = SPD_10;
		rate(4);
		port_stat[0].speed = SPD_100;
		set0(16'hC112);
		rate(4);
		port_stat[0] = '0;
		xfer(1'b1, OFS_RULE_PAIR_A, 32'h8000_0000);
		xfer(1'b1, OFS_RULE_PAIR_B, 32'h0000_0000);
		xfer(1'b1, OFS_MAC_RULE, 32'hFFFF_8000);
		xfer(1'b1, 8'hC0, 32'hFFFF_FFFF);
		rd_chk(OFS_MAC_RULE, 32'h0000_8000, "mac rule upper");
		rd_chk(8'hC0, 32'h0, "unmapped read");
		repeat (4) @(negedge core_clk);
		rd_chk(OFS_PIN_STATE, 32'h0000_0355, "pin levels");
		wrap_up();
	end
endmodule // port_led_rule_controller_tb
